// ===== design/edge_qualifier.v
`timescale 1ns/100ps
`default_nettype none
// Two-sample noise filter followed by edge detection
module edge_qualifier (
   // Clock and reset
   input  wire clk_in,
   input  wire arst_n_in,
   // Sampling
   input  wire sample_en_in,
   input  wire level_in,
   // Detected edges, one-cycle pulses
   output reg  rise_out,
   output reg  fall_out
);

   reg prev_sample;
   reg accepted;

   // Level accepted only after two equal samples in a row
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev_sample <= 1'b0;
         accepted    <= 1'b0;
         rise_out    <= 1'b0;
         fall_out    <= 1'b0;
      end else begin
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         if (sample_en_in) begin
            prev_sample <= level_in;
            if (prev_sample == level_in && accepted != level_in) begin
               accepted <= level_in;
               rise_out <= level_in;
               fall_out <= ~level_in;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== design/timer16_consts.vh
// What this block does
// - Count equal to register A clears count, keeps counting, raises compare-match request.
// - Count source comes from clock-select bits 0 and 1 of prescale register.
// - Compare lowered below count: count runs to wrap through FFFF without setting the overflow flag, resumes from zero.
// - Event mode increments once per qualified valid edge of input A.
// - Input A valid edge from bits 4 and 5: rising, falling or both.
// - Event mode samples input A at clock/8, two matching samples needed.
// - Timer output pin is not driven while pin serves as event input.
// - Capture inputs sampled at count-clock rate, two matching samples needed.
// - Free-running: valid input A edge copies count to B, raises capture request.
// - Input B edge, bits 6 and 7, copies count to A, raises compare request.
// - Single-input two-register mode: opposite input A edge copies count to A.
// - Input A set to both edges: no opposite-edge capture into A.
// - Overflow flag stays set until software clears it.
// - Interval mode raises overflow only when register A is FFFF; free-running, event mode included, raises it at every wrap.
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH

// Register indices
`define REG_TIMER_COUNT   3'h0
`define REG_COMPARE_A     3'h1
`define REG_CAPTURE_B     3'h2
`define REG_PRESCALE      3'h3
`define REG_MODE_CONTROL  3'h4
`define REG_CAPCMP_CTRL   3'h5
`define REG_STATUS        3'h6

// Prescale/edge-select fields
`define CLK_SEL_LO        0
`define CLK_SEL_HI        1
`define EDGE_A_LO         4
`define EDGE_A_HI         5
`define EDGE_B_LO         6
`define EDGE_B_HI         7

// Clock-select codes
`define CLK_SEL_FX        2'h0
`define CLK_SEL_FX4       2'h1
`define CLK_SEL_FX64      2'h2
`define CLK_SEL_EXT       2'h3

// Edge-select codes
`define EDGE_FALL         2'h0
`define EDGE_RISE         2'h1
`define EDGE_BOTH         2'h3

// Mode-control codes
`define MODE_STOP         2'h0
`define MODE_CLEAR_MATCH  2'h1
`define MODE_FREE_RUN     2'h2

// Capture/compare control bits
`define CC_A_CAPTURE      0
`define CC_A_FROM_A_OPP   1
`define CC_OUT_ENABLE     2

// Status bits
`define ST_OVERFLOW       0

// Divider masks for count clocks and event sampling
`define DIV4_MASK         9'h003
`define DIV8_MASK         9'h007
`define DIV64_MASK        9'h03f

// Reset values and maximum count
`define PRESCALE_RST      8'h00
`define MODE_RST          2'h0
`define CAPCMP_RST        3'h0
`define COUNT_RST         16'h0000
`define COMPARE_RST       16'h0000
`define COUNT_MAX         16'hffff

`endif

// ===== design/timer16_interval_event_capture.v
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.vh"
module timer16_interval_event_capture (
   // Clock and reset
   input  wire        clk_in,
   input  wire        arst_n_in,
   // Register port
   input  wire [2:0]  addr_in,
   input  wire [15:0] wr_data_in,
   input  wire        wr_en_in,
   input  wire        rd_en_in,
   output reg  [15:0] rd_data_out,
   // External pins
   input  wire        external_input_a_in,
   input  wire        external_input_b_in,
   output reg         timer_output_pin_out,
   output wire        timer_output_pin_oe_out,
   // Interrupt requests, one-cycle pulses
   output reg         compare_match_irq_out,
   output reg         capture_b_irq_out
);

   reg  [15:0] timer_count;
   reg  [15:0] compare_capture_reg_a;
   reg  [15:0] capture_reg_b;
   reg  [7:0]  prescale_edge_select;
   reg  [1:0]  timer_mode_control;
   reg  [2:0]  capture_compare_control;
   reg         overflow_flag;
   reg  [8:0]  presc;
   reg  [1:0]  sync_a;
   reg  [1:0]  sync_b;
   wire        a_rise;
   wire        a_fall;
   wire        b_rise;
   wire        b_fall;
   reg  [15:0] next_timer_count;
   reg  [15:0] next_compare_a;
   reg         next_overflow;
   reg         next_tout;
   reg  [15:0] next_rd_data;

   wire [1:0] clk_sel = {prescale_edge_select[`CLK_SEL_HI],
                         prescale_edge_select[`CLK_SEL_LO]};
   wire [1:0] edge_a  = {prescale_edge_select[`EDGE_A_HI],
                         prescale_edge_select[`EDGE_A_LO]};
   wire [1:0] edge_b  = {prescale_edge_select[`EDGE_B_HI],
                         prescale_edge_select[`EDGE_B_LO]};
   wire       event_mode = (clk_sel == `CLK_SEL_EXT);
   wire       running    = (timer_mode_control != `MODE_STOP);
   wire       free_run   = (timer_mode_control == `MODE_FREE_RUN);
   wire       a_capture  = capture_compare_control[`CC_A_CAPTURE];
   wire       a_from_opp = capture_compare_control[`CC_A_FROM_A_OPP];

   // Does a detected edge match the selected polarity
   function edge_hit;
      input [1:0] sel;
      input       rise;
      input       fall;
      begin
         case (sel)
            `EDGE_FALL: edge_hit = fall;
            `EDGE_RISE: edge_hit = rise;
            `EDGE_BOTH: edge_hit = rise | fall;
            default:    edge_hit = 1'b0;
         endcase
      end
   endfunction

   // Internal count clocks from a free prescaler
   wire tick_div4  = ((presc & `DIV4_MASK) == `DIV4_MASK);
   wire tick_div8  = ((presc & `DIV8_MASK) == `DIV8_MASK);
   wire tick_div64 = ((presc & `DIV64_MASK) == `DIV64_MASK);

   reg int_tick;
   always @* begin
      case (clk_sel)
         `CLK_SEL_FX:   int_tick = 1'b1;
         `CLK_SEL_FX4:  int_tick = tick_div4;
         `CLK_SEL_FX64: int_tick = tick_div64;
         default:       int_tick = tick_div8;
      endcase
   end

   // Event input sampled at fx/8, capture inputs at count-clock rate
   wire sample_a = event_mode ? tick_div8 : int_tick;
   wire sample_b = int_tick;

   // Free prescaler; never cleared, so tick phase is unrelated to start
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         presc <= 9'h000;
      end else begin
         presc <= presc + 9'h001;
      end
   end

   // Pins are asynchronous: two flops before any logic reads them
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync_a <= 2'b00;
         sync_b <= 2'b00;
      end else begin
         sync_a <= {sync_a[0], external_input_a_in};
         sync_b <= {sync_b[0], external_input_b_in};
      end
   end

   edge_qualifier qual_a (
      .clk_in       (clk_in),
      .arst_n_in    (arst_n_in),
      .sample_en_in (sample_a),
      .level_in     (sync_a[1]),
      .rise_out     (a_rise),
      .fall_out     (a_fall)
   );

   edge_qualifier qual_b (
      .clk_in       (clk_in),
      .arst_n_in    (arst_n_in),
      .sample_en_in (sample_b),
      .level_in     (sync_b[1]),
      .rise_out     (b_rise),
      .fall_out     (b_fall)
   );

   // Valid edges after filtering
   wire a_valid = edge_hit(edge_a, a_rise, a_fall);
   wire b_valid = edge_hit(edge_b, b_rise, b_fall);
   // Opposite edge only defined for single-polarity selection
   reg a_opposite;
   always @* begin
      case (edge_a)
         `EDGE_FALL: a_opposite = a_rise;
         `EDGE_RISE: a_opposite = a_fall;
         default:    a_opposite = 1'b0;
      endcase
   end

   // Count enable: one per count-clock period or per event edge
   wire count_tick = running & (event_mode ? a_valid : int_tick);
   wire match      = !free_run && (timer_count == compare_capture_reg_a);
   wire at_max     = (timer_count == `COUNT_MAX);

   // Captures only while the counter free-runs
   wire cap_b      = running & free_run & a_valid;
   wire cap_a_in_b = running & free_run & a_capture & !a_from_opp
                     & b_valid;
   wire cap_a_opp  = running & free_run & a_capture & a_from_opp
                     & a_opposite;
   wire cap_a      = cap_a_in_b | cap_a_opp;

   // Write strobe aimed at one register index
   function wr_sel;
      input       en;
      input [2:0] addr;
      input [2:0] idx;
      begin
         wr_sel = en & (addr == idx);
      end
   endfunction

   wire wr_a     = wr_sel(wr_en_in, addr_in, `REG_COMPARE_A);
   wire wr_presc = wr_sel(wr_en_in, addr_in, `REG_PRESCALE);
   wire wr_mode  = wr_sel(wr_en_in, addr_in, `REG_MODE_CONTROL);
   wire wr_ctrl  = wr_sel(wr_en_in, addr_in, `REG_CAPCMP_CTRL);
   wire wr_stat  = wr_sel(wr_en_in, addr_in, `REG_STATUS);

   // Overflow events per mode; a lowered compare wraps without a flag
   wire a_is_max = (compare_capture_reg_a == `COUNT_MAX);
   wire ovf_set  = count_tick & at_max &
                   (free_run | (match & a_is_max));
   wire ovf_clr  = wr_stat & wr_data_in[`ST_OVERFLOW];

   // Next count: stop holds zero, match clears, else count up
   always @* begin
      next_timer_count = timer_count;
      if (!running) begin
         next_timer_count = `COUNT_RST;
      end else if (count_tick) begin
         if (match) begin
            next_timer_count = `COUNT_RST;
         end else begin
            // Lowered compare simply wraps through FFFF
            next_timer_count = timer_count + 16'h0001;
         end
      end
   end

   // Hardware capture wins over a software write in the same cycle
   always @* begin
      next_compare_a = compare_capture_reg_a;
      if (cap_a) begin
         next_compare_a = timer_count;
      end else if (wr_a) begin
         next_compare_a = wr_data_in;
      end
   end

   // Set wins over a simultaneous write-one clear
   always @* begin
      next_overflow = overflow_flag;
      if (ovf_set) begin
         next_overflow = 1'b1;
      end else if (ovf_clr) begin
         next_overflow = 1'b0;
      end
   end

   // Counter and capture registers
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         timer_count           <= `COUNT_RST;
         compare_capture_reg_a <= `COMPARE_RST;
         capture_reg_b         <= `COUNT_RST;
      end else begin
         timer_count           <= next_timer_count;
         compare_capture_reg_a <= next_compare_a;
         if (cap_b) begin
            capture_reg_b <= timer_count;
         end
      end
   end

   // Control registers; changing them while running is not guarded
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prescale_edge_select    <= `PRESCALE_RST;
         timer_mode_control      <= `MODE_RST;
         capture_compare_control <= `CAPCMP_RST;
         overflow_flag           <= 1'b0;
      end else begin
         if (wr_presc) begin
            prescale_edge_select <= wr_data_in[7:0];
         end
         if (wr_mode) begin
            timer_mode_control <= wr_data_in[1:0];
         end
         if (wr_ctrl) begin
            capture_compare_control <= wr_data_in[2:0];
         end
         overflow_flag <= next_overflow;
      end
   end

   // Next values of the request pulses and the toggling pin
   wire next_cmp_irq = (count_tick & match) | cap_a_in_b;
   wire next_cap_irq = cap_b;
   always @* begin
      next_tout = timer_output_pin_out;
      if (!running) begin
         next_tout = 1'b0;
      end else if (count_tick & match) begin
         next_tout = ~timer_output_pin_out;
      end
   end

   // Interrupt pulses and timer output
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         compare_match_irq_out <= 1'b0;
         capture_b_irq_out     <= 1'b0;
         timer_output_pin_out  <= 1'b0;
      end else begin
         compare_match_irq_out <= next_cmp_irq;
         capture_b_irq_out     <= next_cap_irq;
         timer_output_pin_out  <= next_tout;
      end
   end

   // Pin is input-only while it feeds the event counter
   assign timer_output_pin_oe_out =
      capture_compare_control[`CC_OUT_ENABLE] & !event_mode;

   // Read mux; zero outside the read slot so stale data never lingers
   always @* begin
      next_rd_data = 16'h0000;
      if (rd_en_in) begin
         case (addr_in)
            `REG_TIMER_COUNT:  next_rd_data = timer_count;
            `REG_COMPARE_A:    next_rd_data = compare_capture_reg_a;
            `REG_CAPTURE_B:    next_rd_data = capture_reg_b;
            `REG_PRESCALE:     next_rd_data = {8'h00, prescale_edge_select};
            `REG_MODE_CONTROL: next_rd_data = {14'h0000, timer_mode_control};
            `REG_CAPCMP_CTRL:
               next_rd_data = {13'h0000, capture_compare_control};
            `REG_STATUS:       next_rd_data = {15'h0000, overflow_flag};
            default:           next_rd_data = 16'h0000;
         endcase
      end
   end

   // Read data, one cycle after the strobe
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= 16'h0000;
      end else begin
         rd_data_out <= next_rd_data;
      end
   end

endmodule
`default_nettype wire

// ===== dv/pulse_source.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_source (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   // Pulse requests
   input  wire logic       fire_a_in,
   input  wire logic       fire_b_in,
   input  wire logic [7:0] width_in,
   // Pin levels
   output wire logic       pin_a_out,
   output wire logic       pin_b_out
);
   logic [7:0] left_a;
   logic [7:0] left_b;
   // Push-pull pins that idle low between pulses
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         left_a <= 8'h00;
         left_b <= 8'h00;
      end else begin
         left_a <= fire_a_in ? width_in : left_a - {7'h00, left_a != 8'h00};
         left_b <= fire_b_in ? width_in : left_b - {7'h00, left_b != 8'h00};
      end
   end
   assign pin_a_out = left_a != 8'h00;
   assign pin_b_out = left_b != 8'h00;
endmodule
`default_nettype wire

// ===== dv/timer16_checker_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.vh"
module timer16_checker (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        arst_n_in,
   // Register port
   input wire logic [2:0]  addr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic        wr_en_in,
   input wire logic        rd_en_in,
   input wire logic [15:0] rd_data_out,
   // Pin and requests
   input wire logic        timer_output_pin_out,
   input wire logic        timer_output_pin_oe_out,
   input wire logic        compare_match_irq_out,
   input wire logic        capture_b_irq_out
);
   logic [7:0] presc_sh;
   logic [1:0] mode_sh;
   // Shadow copies, since the checker cannot see inside the block
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         presc_sh <= 8'h00;
         mode_sh  <= 2'h0;
      end else if (wr_en_in) begin
         if (addr_in == `REG_PRESCALE)
            presc_sh <= wr_data_in[7:0];
         if (addr_in == `REG_MODE_CONTROL)
            mode_sh <= wr_data_in[1:0];
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   AST_RD_IDLE:
      assert property (!$past(rd_en_in) |-> rd_data_out == 16'h0000)
      else $error("read data not zero outside read slot");
   AST_UNMAPPED_ZERO:
      assert property (rd_en_in && addr_in == 3'h7 |=> rd_data_out == 16'h0000)
      else $error("unmapped index read not zero");
   AST_PRESCALE_READBACK:
      assert property (rd_en_in && addr_in == `REG_PRESCALE
                       |=> rd_data_out == {8'h00, presc_sh})
      else $error("prescale readback mismatch");
   AST_OE_EVENT:
      assert property (presc_sh[1:0] == `CLK_SEL_EXT
                       |-> !timer_output_pin_oe_out)
      else $error("output driven in event mode");
   AST_CMP_PULSE:
      assert property (compare_match_irq_out |=> !compare_match_irq_out)
      else $error("compare request longer than one cycle");
   AST_STOP_QUIET:
      assert property (mode_sh == 2'h0 && $past(mode_sh) == 2'h0 |->
         !(compare_match_irq_out || capture_b_irq_out || timer_output_pin_out))
      else $error("activity while stopped");
   AST_CAP_FREE_ONLY:
      assert property (capture_b_irq_out |-> $past(mode_sh) == `MODE_FREE_RUN)
      else $error("capture request outside free run");
   AST_CAP_PULSE:
      assert property (capture_b_irq_out |=> !capture_b_irq_out)
      else $error("capture request longer than one cycle");
   cover property (compare_match_irq_out);
   cover property (capture_b_irq_out);
   cover property (rd_en_in && addr_in == `REG_STATUS);
endmodule
bind timer16_interval_event_capture timer16_checker u_checker (
   .clk_in                  (clk_in),
   .arst_n_in               (arst_n_in),
   .addr_in                 (addr_in),
   .wr_data_in              (wr_data_in),
   .wr_en_in                (wr_en_in),
   .rd_en_in                (rd_en_in),
   .rd_data_out             (rd_data_out),
   .timer_output_pin_out    (timer_output_pin_out),
   .timer_output_pin_oe_out (timer_output_pin_oe_out),
   .compare_match_irq_out   (compare_match_irq_out),
   .capture_b_irq_out       (capture_b_irq_out)
);
`default_nettype wire

// ===== dv/timer16_interval_event_capture_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer16_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module timer16_interval_event_capture_bench;
   logic        clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic [2:0]  addr_in = 3'h0;
   logic [15:0] wr_data_in = 16'h0000;
   logic        wr_en_in = 1'b0;
   logic        rd_en_in = 1'b0;
   logic        fire_a = 1'b0;
   logic        fire_b = 1'b0;
   logic [7:0]  width = 8'h00;
   wire  [15:0] rd_data;
   wire         pin_a, pin_b, tout, tout_oe, cmp_irq, cap_irq;
   int          failures = 0;
   int          samples_checked = 0;
   int          c;
   logic [15:0] rv, v1;
   logic [15:0] ecode [3] = '{16'h0003, 16'h0013, 16'h0033};
   logic [15:0] ecnt [3] = '{16'h0002, 16'h0002, 16'h0004};
   always #20 clk_in = ~clk_in;
   pulse_source u_src (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .fire_a_in(fire_a), .fire_b_in(fire_b), .width_in(width),
      .pin_a_out(pin_a), .pin_b_out(pin_b));
   timer16_interval_event_capture uut (.clk_in(clk_in),
      .arst_n_in(arst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
      .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data),
      .external_input_a_in(pin_a), .external_input_b_in(pin_b),
      .timer_output_pin_out(tout), .timer_output_pin_oe_out(tout_oe),
      .compare_match_irq_out(cmp_irq), .capture_b_irq_out(cap_irq));
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 rv = rd_data;
   endtask
   task automatic start(input logic [15:0] cc, a, pr, md);
      wr(`REG_MODE_CONTROL, 16'h0000);
      wr(`REG_CAPCMP_CTRL, cc);
      wr(`REG_COMPARE_A, a);
      wr(`REG_PRESCALE, pr);
      wr(`REG_MODE_CONTROL, md);
   endtask
   task automatic pulse(input bit b, input logic [7:0] w);
      @(posedge clk_in);
      width <= w;
      fire_a <= !b;
      fire_b <= b;
      @(posedge clk_in);
      fire_a <= 1'b0;
      fire_b <= 1'b0;
   endtask
   task automatic wait_ev(input bit cap);
      c = 0;
      do begin
         @(negedge clk_in);
         c++;
      end while ((cap ? cap_irq : cmp_irq) !== 1'b1 && c < 1000);
   endtask
   task automatic test_regs;
      wr(3'h7, 16'hffff);
      wr(`REG_TIMER_COUNT, 16'h1234);
      for (int i = 0; i < 8; i++) begin
         rd(i[2:0]);
         `CHK(rv, 16'h0000)
      end
      rd(`REG_TIMER_COUNT);
      `CHK(rv, 16'h0000)
      $display("test_regs done");
   endtask
   task automatic test_interval;
      for (int n = 0; n < 3; n++) begin
         start(16'h0000, 16'h0003, n[15:0], 16'h0001);
         wait_ev(0);
         v1 = {15'h0000, tout};
         wait_ev(0);
         `CHK(c, n == 0 ? 4 : n == 1 ? 16 : 256)
         `CHK(tout, ~v1[0])
      end
      $display("test_interval done");
   endtask
   task automatic test_lower;
      start(16'h0000, 16'h8000, 16'h0000, 16'h0001);
      repeat (200) @(posedge clk_in);
      wr(`REG_COMPARE_A, 16'h0008);
      rd(`REG_TIMER_COUNT);
      v1 = rv;
      repeat (50) @(posedge clk_in);
      rd(`REG_TIMER_COUNT);
      `CHK(rv - v1, 16'd52)
      rd(`REG_STATUS);
      `CHK(rv, 16'h0000)
      start(16'h0000, 16'h0008, 16'h0000, 16'h0001);
      $display("test_lower done");
   endtask
   task automatic test_event;
      for (int i = 0; i < 3; i++) begin
         start(16'h0004, 16'h0005, ecode[i], 16'h0001);
         `CHK(tout_oe, 1'b0)
         pulse(0, 8'h03);
         repeat (40) @(posedge clk_in);
         pulse(0, 8'h18);
         repeat (50) @(posedge clk_in);
         pulse(0, 8'h18);
         repeat (50) @(posedge clk_in);
         rd(`REG_TIMER_COUNT);
         `CHK(rv, ecnt[i])
      end
      $display("test_event done");
   endtask
   task automatic test_capture;
      start(16'h0003, 16'h1234, 16'h0030, 16'h0002);
      pulse(0, 8'h28);
      wait_ev(1);
      rd(`REG_CAPTURE_B);
      v1 = rv;
      wait_ev(1);
      rd(`REG_CAPTURE_B);
      `CHK(rv - v1, 16'd40)
      rd(`REG_COMPARE_A);
      `CHK(rv, 16'h1234)
      start(16'h0003, 16'h0000, 16'h0010, 16'h0002);
      pulse(0, 8'h28);
      wait_ev(1);
      rd(`REG_CAPTURE_B);
      v1 = rv;
      repeat (60) @(posedge clk_in);
      rd(`REG_COMPARE_A);
      `CHK(rv - v1, 16'd40)
      start(16'h0001, 16'h0000, 16'h0050, 16'h0002);
      pulse(0, 8'h3c);
      repeat (29) @(posedge clk_in);
      pulse(1, 8'h3c);
      wait_ev(0);
      `CHK(c < 1000, 1'b1)
      rd(`REG_COMPARE_A);
      v1 = rv;
      rd(`REG_CAPTURE_B);
      `CHK(v1 - rv, 16'd31)
      $display("test_capture done");
   endtask
   task automatic test_overflow;
      wr(`REG_STATUS, 16'h0001);
      rd(`REG_STATUS);
      `CHK(rv, 16'h0000)
      // A full count span guarantees exactly one wrap at fx
      repeat (65536) @(posedge clk_in);
      rd(`REG_STATUS);
      `CHK(rv, 16'h0001)
      repeat (100) @(posedge clk_in);
      rd(`REG_STATUS);
      `CHK(rv, 16'h0001)
      wr(`REG_STATUS, 16'h0001);
      rd(`REG_STATUS);
      `CHK(rv, 16'h0000)
      $display("test_overflow done");
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      arst_n_in <= 1'b1;
      test_regs;
      test_interval;
      test_lower;
      test_event;
      test_capture;
      test_overflow;
      complete_run;
   end
   // About 100000 cycles, well past the planned run
   initial begin
      #4000000;
      failures++;
      complete_run;
   end
endmodule
`default_nettype wire
